// [core/sbr_pkg.sv]
// Package for the serial baud rate generator: register map, fields, reset values
package sbr_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] SBR_RATE_OFFS   = 8'h00;
  localparam logic [7:0] SBR_STATUS_OFFS = 8'h04;
  // Field positions inside the rate select register
  localparam int         SBR_RATE_LSB    = 0;
  localparam int         SBR_RATE_MSB    = 2;
  localparam int         SBR_PRE_LSB     = 4;
  localparam int         SBR_PRE_MSB     = 5;
  localparam logic [7:0] SBR_RATE_RST    = 8'h00;
  localparam logic [7:0] SBR_RATE_WMASK  = 8'h37;
  // Fixed sixty-four stage and prescale divisors
  localparam int         SBR_FIXED_DIV   = 64;
  localparam logic [3:0] SBR_PD_00       = 4'h1;
  localparam logic [3:0] SBR_PD_01       = 4'h3;
  localparam logic [3:0] SBR_PD_10       = 4'h4;
  localparam logic [3:0] SBR_PD_11       = 4'hD;
  // AXI responses
  localparam logic [1:0] SBR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SBR_RESP_SLVERR = 2'h2;
endpackage

// [core/sbr_baud_gen.sv]
// Serial baud rate generator with an AXI4-Lite register slave
// Function
// - One divisor setting gives one rate shared by receiver and transmitter.
// - Prescale select 00,01,10,11 divides by 1,3,4,13.
// - Reset clears prescale and rate select, both divisors become one.
// - Rate select n divides by two to the power n, up to 128.
// - Bit rate is module clock over 64 times prescale times rate divisor.
`timescale 1ns/1ps
`default_nettype none
module sbr_baud_gen
  import sbr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             baud_tick,
  output logic [7:0]       rate_sel_out
);

  function automatic logic [3:0] prescale_divisor(input logic [1:0] sel);
    logic [3:0] d;
    d = SBR_PD_00;
    case (sel)
      2'h0: d = SBR_PD_00;
      2'h1: d = SBR_PD_01;
      2'h2: d = SBR_PD_10;
      default: d = SBR_PD_11;
    endcase
    return d;
  endfunction

  logic [7:0]  serial_rate_select_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        restart_reg;
  logic [5:0]  fix_cnt_reg;
  logic [3:0]  pre_cnt_reg;
  logic [6:0]  rate_cnt_reg;
  logic [1:0]  prescale_sel;
  logic [2:0]  rate_sel;
  logic [3:0]  prescale_div;
  logic [7:0]  rate_divisor;
  logic        fix_tick;
  logic        pre_tick;
  logic        wr_fire;

  assign prescale_sel = serial_rate_select_reg[SBR_PRE_MSB:SBR_PRE_LSB];
  assign rate_sel     = serial_rate_select_reg[SBR_RATE_MSB:SBR_RATE_LSB];
  assign prescale_div = prescale_divisor(prescale_sel);
  assign rate_divisor = 8'h01 << rate_sel;
  assign wr_fire      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_rate_select_reg <= SBR_RATE_RST;
      restart_reg            <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (wr_fire && aw_addr_reg[7:2] == SBR_RATE_OFFS[7:2] && w_strb_reg[0]) begin
        serial_rate_select_reg <= w_data_reg[7:0] & SBR_RATE_WMASK;
        restart_reg            <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SBR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg[7:2] == SBR_RATE_OFFS[7:2]) begin
        s_axi_bresp <= SBR_RESP_OKAY;
      end else if (aw_addr_reg[7:2] == SBR_STATUS_OFFS[7:2]) begin
        s_axi_bresp <= SBR_RESP_OKAY;
      end else begin
        s_axi_bresp <= SBR_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path; status word shows live counter state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SBR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (s_axi_araddr[7:2] == SBR_RATE_OFFS[7:2]) begin
        s_axi_rdata <= {24'h00_0000, serial_rate_select_reg};
        s_axi_rresp <= SBR_RESP_OKAY;
      end else if (s_axi_araddr[7:2] == SBR_STATUS_OFFS[7:2]) begin
        s_axi_rdata <= {15'h0000, rate_cnt_reg, pre_cnt_reg, fix_cnt_reg};
        s_axi_rresp <= SBR_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= SBR_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  assign fix_tick = (fix_cnt_reg == 6'(SBR_FIXED_DIV - 1));
  assign pre_tick = fix_tick && (pre_cnt_reg == prescale_div - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn || restart_reg) begin
      fix_cnt_reg <= 6'h00;
    end else begin
      fix_cnt_reg <= fix_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || restart_reg) begin
      pre_cnt_reg <= 4'h0;
    end else if (pre_tick) begin
      pre_cnt_reg <= 4'h0;
    end else if (fix_tick) begin
      pre_cnt_reg <= pre_cnt_reg + 4'h1;
    end
  end

  // rate stage, pulse not gated clock
  always_ff @(posedge aclk) begin
    if (!aresetn || restart_reg) begin
      rate_cnt_reg <= 7'h00;
      baud_tick    <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (pre_tick) begin
        if ({1'b0, rate_cnt_reg} == rate_divisor - 8'h01) begin
          rate_cnt_reg <= 7'h00;
          baud_tick    <= 1'b1;
        end else begin
          rate_cnt_reg <= rate_cnt_reg + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_sel_out <= SBR_RATE_RST;
    end else begin
      rate_sel_out <= serial_rate_select_reg;
    end
  end

endmodule
`default_nettype wire

// [dv/sbr_far_end.sv]
// Far-end model measuring the shared bit period
`timescale 1ns/1ps
`default_nettype none
module sbr_far_end (
  input  wire logic        aclk,
  input  wire logic        baud_tick,
  output var  logic [31:0] gap
);
  logic [31:0] cnt = 32'h0;
  always @(posedge aclk) begin
    gap <= baud_tick ? cnt + 32'h1 : gap;
    cnt <= baud_tick ? 32'h0 : cnt + 32'h1;
  end
endmodule
`default_nettype wire

// [dv/sbr_assertions.sv]
// Checker for tick timing and bus handshakes
`timescale 1ns/1ps
`default_nettype none
module sbr_checker
  import sbr_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        baud_tick,
  input wire logic [7:0]  rate_sel_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] cnt;
  logic        seen;
  logic [3:0]  pd;
  assign pd = rate_sel_out[5] ? (rate_sel_out[4] ? SBR_PD_11 : SBR_PD_10) : (rate_sel_out[4] ? SBR_PD_01 : SBR_PD_00);
  // A rate register write restarts the chain, so the gap after any write is skipped
  always_ff @(posedge aclk) begin
    cnt  <= baud_tick ? 32'h0 : cnt + 32'h1;
    seen <= aresetn && (baud_tick || seen) && !s_axi_bvalid;
  end
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  property p_pulse; baud_tick |=> !baud_tick [*8]; endproperty
  property p_period; baud_tick && seen |-> cnt == SBR_FIXED_DIV * pd * (1 << rate_sel_out[2:0]) - 1; endproperty
  property p_rst; $rose(aresetn) |-> rate_sel_out == SBR_RATE_RST && !baud_tick; endproperty
  property p_mask; (rate_sel_out & ~SBR_RATE_WMASK) == 8'h00; endproperty
  property p_rd; s_ar |=> s_axi_rvalid; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_pulse: assert property (p_pulse) else $error("tick too wide");
  a_period: assert property (p_period) else $error("tick period");
  a_rst: assert property (p_rst) else $error("reset value");
  a_mask: assert property (p_mask) else $error("unused bits set");
  a_rd: assert property (p_rd) else $error("read late");
  a_rhold: assert property (p_rhold) else $error("read dropped");
  a_bhold: assert property (p_bhold) else $error("write resp dropped");
  a_arblk: assert property (p_arblk) else $error("read accepted");
endmodule
bind sbr_baud_gen sbr_checker chk (.*);
`default_nettype wire

// [dv/tb_sbr_baud_gen.sv]
// Testbench for the serial baud rate generator
`timescale 1ns/1ps
`default_nettype none
module tb_sbr_baud_gen;
  import sbr_pkg::*;
  logic        aclk, aresetn, baud_tick, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rate_sel_out;
  logic [31:0] s_axi_wdata, s_axi_rdata, gap, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          err_total, compares, i;
  logic [3:0]  pdv [4] = '{SBR_PD_00, SBR_PD_01, SBR_PD_10, SBR_PD_11};
  sbr_baud_gen uut (.*);
  sbr_far_end  far (.aclk(aclk), .baud_tick(baud_tick), .gap(gap));
  always #20 aclk = ~aclk;
  task automatic wrap_up;
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(int n);
    if (n == 0) begin
      err_total++;
      wrap_up;
    end
  endtask
  // Ready held back a little so responses must wait
  task automatic wr(logic [7:0] a, logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 200; i > 0; i--) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= i < 198;
    end
    hang(i);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 200; i > 0; i--) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= i < 200;
    end
    hang(i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Third tick after a restart gives a clean period
  task automatic meas(int exp);
    repeat (3) begin
      for (i = 20000; i > 0; i--) begin
        @(posedge aclk);
        if (baud_tick) break;
      end
      hang(i);
    end
    @(posedge aclk);
    chk("period", gap, exp);
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_total, compares} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SBR_RATE_OFFS);
    chk("rate reset", d, 32'h0);
    wr(SBR_RATE_OFFS, 32'hFF);
    rd(SBR_RATE_OFFS);
    chk("rate bits", d, {24'h0, SBR_RATE_WMASK});
    rd(8'h08);
    chk("unmapped resp", {30'h0, r}, {30'h0, SBR_RESP_SLVERR});
    wr(8'h08, 32'h0);
    chk("unmapped wr resp", {30'h0, r}, {30'h0, SBR_RESP_SLVERR});
    s_axi_wstrb <= 4'hE;
    wr(SBR_RATE_OFFS, 32'h00);
    chk("masked wr resp", {30'h0, r}, {30'h0, SBR_RESP_OKAY});
    s_axi_wstrb <= 4'hF;
    rd(SBR_RATE_OFFS);
    chk("strobe off", d, {24'h0, SBR_RATE_WMASK});
    for (int k = 0; k < 4; k++) begin
      wr(SBR_RATE_OFFS, 32'(k << 4));
      meas(SBR_FIXED_DIV * pdv[k]);
    end
    for (int k = 0; k < 8; k++) begin
      wr(SBR_RATE_OFFS, 32'(k));
      meas(SBR_FIXED_DIV << k);
    end
    wr(SBR_RATE_OFFS, 32'h31);
    meas(SBR_FIXED_DIV * pdv[3] * 2);
    chk("rate copy", {24'h0, rate_sel_out}, 32'h31);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("rate after reset", {24'h0, rate_sel_out}, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
